//--- master_clock_ctrl.sv
// Master subsystem clock selection, clock failure and low-power control
`timescale 1ns/1ps
`include "mclk_defs.svh"
module master_clock_ctrl #(
   parameter int NPERIPH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core events and clock monitor tick, from other domains
   input wire logic wfi_event,
   input wire logic irq_event,
   input wire logic isr_done,
   input wire logic osc_tick,
   // Clock steering outputs
   output logic sys_src_pll,
   output logic sys_src_backup,
   output logic main_pll_on,
   output logic usb_pll_on,
   output logic usb_bypass,
   output logic [5:0] usb_mult,
   output logic cpu_clk_on,
   output logic ctl_clk_on,
   output logic analog_clk_on,
   output logic analog_undivided,
   output logic [1:0] ds_src,
   output logic [NPERIPH-1:0] periph_gate,
   output logic clock_failure_signal,
   output logic [2:0] mode_out
);
   logic [2:0] ev_s1_q, ev_s2_q, ev_s3_q;
   logic tick_s1_q, tick_s2_q, tick_s3_q;
   logic [31:0] pll_ctl_q, sys_div_q, m_div_q, a_div_q, ds_cfg_q, rcc_q;
   logic [31:0] sys_ctrl_q;
   logic [5:0] usb_mult_q;
   logic [NPERIPH-1:0] run_g_q, slp_g_q, ds_g_q, dev_q;
   logic [3:0] miss_cnt_q;
   logic fail_q;
   mclk_pkg::owner_t own_q;
   mclk_pkg::mode_t mode_q;
   logic in_isr_q;
   logic wr, rd;
   logic [NPERIPH-1:0] gate_d;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;

   // Two-stage synchronisers; third stage only for edge detection
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ev_s1_q <= 3'h0;
         ev_s2_q <= 3'h0;
         ev_s3_q <= 3'h0;
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_s3_q <= 1'b0;
      end else begin
         ev_s1_q <= {isr_done, irq_event, wfi_event};
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
         tick_s1_q <= osc_tick;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
      end
   end

   wire wfi_p = ev_s2_q[0] & ~ev_s3_q[0];
   wire irq_p = ev_s2_q[1] & ~ev_s3_q[1];
   wire done_p = ev_s2_q[2] & ~ev_s3_q[2];
   wire tick_p = tick_s2_q ^ tick_s3_q;

   // Writes to ADDR_PLL_CTL and ADDR_SYS_DIV land only while own_q is OWN_MASTER; otherwise
   // any write to them is dropped silently but still answered
   wire pll_wr_ok = (own_q == mclk_pkg::OWN_MASTER);

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pll_ctl_q <= 32'h0;
         sys_div_q <= 32'h0;
         usb_mult_q <= 6'h0;
         m_div_q <= 32'h0;
         a_div_q <= 32'h0;
         ds_cfg_q <= 32'h0;
         rcc_q <= 32'h0;
         sys_ctrl_q <= 32'h0;
         run_g_q <= '0;
         slp_g_q <= '0;
         ds_g_q <= '0;
         dev_q <= '1;
      end else if (wr) begin
         if (hit(paddr, `ADDR_PLL_CTL) && pll_wr_ok)
            pll_ctl_q <= pwdata;
         if (hit(paddr, `ADDR_SYS_DIV) && pll_wr_ok)
            sys_div_q <= pwdata;
         if (hit(paddr, `ADDR_USB_MULT))
            usb_mult_q <= pwdata[5:0];
         if (hit(paddr, `ADDR_M_DIV))
            m_div_q <= pwdata;
         if (hit(paddr, `ADDR_A_DIV))
            a_div_q <= pwdata;
         if (hit(paddr, `ADDR_DS_CFG))
            ds_cfg_q <= pwdata;
         if (hit(paddr, `ADDR_RCC))
            rcc_q <= pwdata;
         if (hit(paddr, `ADDR_SYS_CTRL))
            sys_ctrl_q <= pwdata;
         if (hit(paddr, `ADDR_RUN_GATE))
            run_g_q <= pwdata[NPERIPH-1:0];
         if (hit(paddr, `ADDR_SLP_GATE))
            slp_g_q <= pwdata[NPERIPH-1:0];
         if (hit(paddr, `ADDR_DS_GATE))
            ds_g_q <= pwdata[NPERIPH-1:0];
         if (hit(paddr, `ADDR_DEV_CFG))
            dev_q <= pwdata[NPERIPH-1:0];
      end
   end

   // Ownership handover: a request only lands once the holder released
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         own_q <= mclk_pkg::OWN_MASTER;
      end else if (wr && hit(paddr, `ADDR_OWNER)) begin
         if (own_q == mclk_pkg::OWN_MASTER && pwdata[`CTL_REQ_BIT]
             && pwdata[`M_RELEASE_BIT])
            own_q <= mclk_pkg::OWN_CONTROL;
         else if (own_q == mclk_pkg::OWN_CONTROL && pwdata[`M_RECLAIM_BIT]
             && pwdata[`C_RELEASE_BIT])
            own_q <= mclk_pkg::OWN_MASTER;
      end
   end

   // Missing clock: the oscillator tick must toggle within the timeout.
   // Fail is sticky until reset; a flapping source must not glitch clocks.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         miss_cnt_q <= 4'h0;
         fail_q <= 1'b0;
      end else begin
         if (tick_p)
            miss_cnt_q <= 4'h0;
         else if (miss_cnt_q != 4'(`MISS_TIMEOUT))
            miss_cnt_q <= miss_cnt_q + 4'h1;
         if (miss_cnt_q == 4'(`MISS_TIMEOUT))
            fail_q <= 1'b1;
      end
   end

   // Low-power mode machine
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= mclk_pkg::MODE_RUN;
         in_isr_q <= 1'b0;
      end else begin
         case (mode_q)
            mclk_pkg::MODE_RUN: begin
               if (done_p && in_isr_q) begin
                  in_isr_q <= 1'b0;
                  if (sys_ctrl_q[`EXIT_BIT])
                     mode_q <= sys_ctrl_q[`DEEP_BIT] ?
                        mclk_pkg::MODE_DEEP : mclk_pkg::MODE_SLEEP;
               end else if (wfi_p) begin
                  mode_q <= sys_ctrl_q[`DEEP_BIT] ?
                     mclk_pkg::MODE_DEEP : mclk_pkg::MODE_SLEEP;
               end
            end
            mclk_pkg::MODE_SLEEP, mclk_pkg::MODE_DEEP: begin
               if (irq_p) begin
                  mode_q <= mclk_pkg::MODE_RUN;
                  in_isr_q <= 1'b1;
               end
            end
            default: mode_q <= mclk_pkg::MODE_RUN;
         endcase
      end
   end

   // Peripheral gating per mode, masked by device enable
   always_comb begin
      case (mode_q)
         mclk_pkg::MODE_SLEEP:
            gate_d = rcc_q[`ACG_BIT] ? slp_g_q : run_g_q;
         mclk_pkg::MODE_DEEP:
            gate_d = rcc_q[`ACG_BIT] ? ds_g_q : run_g_q;
         default: gate_d = run_g_q;
      endcase
      gate_d = gate_d & dev_q;
   end

   wire deep = (mode_q == mclk_pkg::MODE_DEEP);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sys_src_pll <= 1'b0;
         sys_src_backup <= 1'b0;
         main_pll_on <= 1'b1;
         usb_pll_on <= 1'b1;
         usb_bypass <= 1'b1;
         usb_mult <= 6'h0;
         cpu_clk_on <= 1'b1;
         ctl_clk_on <= 1'b1;
         analog_clk_on <= 1'b1;
         analog_undivided <= 1'b0;
         ds_src <= `DS_SRC_SLOW;
         periph_gate <= '0;
         clock_failure_signal <= 1'b0;
         mode_out <= 3'h1;
      end else begin
         // enable selects PLL unless fail_q, else oscillator; fail_q selects backup
         sys_src_pll <= pll_ctl_q[`PLL_EN_BIT] && !fail_q;
         sys_src_backup <= fail_q;
         main_pll_on <= !deep;
         usb_pll_on <= !deep;
         usb_bypass <= (usb_mult_q == 6'h0);
         usb_mult <= usb_mult_q;
         cpu_clk_on <= (mode_q == mclk_pkg::MODE_RUN);
         ctl_clk_on <= !deep;
         analog_clk_on <= !deep;
         analog_undivided <= fail_q;
         ds_src <= ds_cfg_q[1:0];
         periph_gate <= gate_d;
         clock_failure_signal <= fail_q;
         mode_out <= mode_q;
      end
   end

   // APB: zero wait states, error on address above ADDR_GATE_OUT
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (paddr > `ADDR_GATE_OUT);
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `ADDR_PLL_CTL: prdata <= pll_ctl_q;
               `ADDR_USB_MULT: prdata <= {26'h0, usb_mult_q};
               `ADDR_SYS_DIV: prdata <= sys_div_q;
               `ADDR_M_DIV: prdata <= m_div_q;
               `ADDR_A_DIV: prdata <= a_div_q;
               `ADDR_DS_CFG: prdata <= ds_cfg_q;
               `ADDR_RUN_GATE: prdata <= 32'(run_g_q);
               `ADDR_SLP_GATE: prdata <= 32'(slp_g_q);
               `ADDR_DS_GATE: prdata <= 32'(ds_g_q);
               `ADDR_DEV_CFG: prdata <= 32'(dev_q);
               `ADDR_RCC: prdata <= rcc_q;
               `ADDR_SYS_CTRL: prdata <= sys_ctrl_q;
               `ADDR_OWNER: prdata <= {30'h0, own_q};
               `ADDR_STATUS: prdata <= {28'h0, fail_q, mode_q};
               `ADDR_GATE_OUT: prdata <= 32'(gate_d);
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   property p_fail_out;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(fail_q) |=> clock_failure_signal && sys_src_backup;
   endproperty
   a_fail_out: assert property (p_fail_out) else $error("fail not shown");

   property p_deep_off;
      @(posedge ref_clk) disable iff (!nrst)
      deep |=> !main_pll_on && !ctl_clk_on && !analog_clk_on;
   endproperty
   a_deep_off: assert property (p_deep_off) else $error("deep clocks on");

   property p_wake;
      @(posedge ref_clk) disable iff (!nrst)
      (mode_q != mclk_pkg::MODE_RUN) && irq_p |=>
         mode_q == mclk_pkg::MODE_RUN;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");

   property p_gate_mask;
      @(posedge ref_clk) disable iff (!nrst)
      ##1 (periph_gate & ~$past(dev_q)) == '0;
   endproperty
   a_gate_mask: assert property (p_gate_mask) else $error("gate leak");

   property p_bypass;
      @(posedge ref_clk) disable iff (!nrst)
      usb_mult_q == 6'h0 |=> usb_bypass;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass lost");

   property p_owner_reset;
      @(posedge ref_clk) $rose(nrst) |-> own_q == mclk_pkg::OWN_MASTER;
   endproperty
   a_owner_reset: assert property (p_owner_reset) else $error("owner");

   property p_wfi_deep;
      @(posedge ref_clk) disable iff (!nrst)
      (mode_q == mclk_pkg::MODE_RUN) && wfi_p && !(done_p && in_isr_q)
         && sys_ctrl_q[`DEEP_BIT] |=> deep ##1 !cpu_clk_on;
   endproperty
   a_wfi_deep: assert property (p_wfi_deep) else $error("no deep");

   property p_sleep_gate;
      @(posedge ref_clk) disable iff (!nrst)
      mode_q == mclk_pkg::MODE_SLEEP && !rcc_q[`ACG_BIT] |=>
         periph_gate == ($past(run_g_q) & $past(dev_q));
   endproperty
   a_sleep_gate: assert property (p_sleep_gate) else $error("gating");
endmodule

//--- mclk_defs.svh
// Constants for the master clock and low-power controller
`ifndef MCLK_DEFS_SVH
`define MCLK_DEFS_SVH
`define ADDR_PLL_CTL      12'h000
`define ADDR_USB_MULT     12'h004
`define ADDR_SYS_DIV      12'h008
`define ADDR_M_DIV        12'h00c
`define ADDR_A_DIV        12'h010
`define ADDR_DS_CFG       12'h014
`define ADDR_RUN_GATE     12'h018
`define ADDR_SLP_GATE     12'h01c
`define ADDR_DS_GATE      12'h020
`define ADDR_DEV_CFG      12'h024
`define ADDR_RCC          12'h028
`define ADDR_SYS_CTRL     12'h02c
`define ADDR_OWNER        12'h030
`define ADDR_STATUS       12'h034
`define ADDR_GATE_OUT     12'h038
`define PLL_EN_BIT        0
`define ACG_BIT           0
`define DEEP_BIT          2
`define EXIT_BIT          1
`define CTL_REQ_BIT       0
`define M_RECLAIM_BIT     1
`define M_RELEASE_BIT     2
`define C_RELEASE_BIT     3
`define USB_FIELD_W       6
`define USB_DIV           4
`define USB_PLL_MHZ       240
`define USB_CLK_MHZ       60
`define MISS_TIMEOUT      8
`define DS_SRC_SLOW       2'h0
`define DS_SRC_FAST       2'h1
`define DS_SRC_OSC        2'h2
`endif

//--- mclk_pkg.sv
// Types for the master clock and low-power controller
package mclk_pkg;
   typedef enum logic [2:0] {
      MODE_RUN = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_DEEP = 3'b100
   } mode_t;
   typedef enum logic [1:0] {
      OWN_MASTER = 2'b01,
      OWN_CONTROL = 2'b10
   } owner_t;
endpackage

//--- core_partner.sv
// Oscillator heartbeat source standing beside the controller
`timescale 1ns/1ps
module core_partner (
   // Command from the bench
   input wire logic src_alive,
   // Heartbeat toward the missing-clock detector
   output logic osc_tick
);
   // Period unrelated to the system clock; an edge that lands on a clock
   // edge is absorbed by the controller's two-stage synchroniser
   initial begin
      osc_tick = 1'b0;
      forever begin
         #17;
         if (src_alive) begin
            osc_tick = ~osc_tick;
         end
      end
   end
endmodule

//--- master_clock_and_low_power_control_tb.sv
// Self-checking bench for the master clock and low-power controller
`timescale 1ns/1ps
`include "mclk_defs.svh"
module master_clock_and_low_power_control_tb;
   logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err, alive;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] evs, mode_out;
   logic sys_src_pll, sys_src_backup, main_pll_on, usb_pll_on, usb_bypass;
   logic cpu_clk_on, ctl_clk_on, analog_clk_on, analog_undivided;
   logic clock_failure_signal, osc_tick;
   logic [5:0] usb_mult;
   logic [1:0] ds_src;
   logic [15:0] periph_gate;
   logic [31:0] codes [4];
   int errors, num_checks;
   master_clock_ctrl #(.NPERIPH(16)) master_clock_ctrl_i (
      .ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr,
      .wfi_event(evs[0]), .irq_event(evs[1]), .isr_done(evs[2]),
      .osc_tick, .sys_src_pll, .sys_src_backup, .main_pll_on, .usb_pll_on,
      .usb_bypass, .usb_mult, .cpu_clk_on, .ctl_clk_on, .analog_clk_on,
      .analog_undivided, .ds_src, .periph_gate, .clock_failure_signal,
      .mode_out
   );
   core_partner core_partner_i (.src_alive(alive), .osc_tick);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Entered just after a rising edge; two edges pass after the access
   // edge so that registered outputs have settled when the caller looks
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   // Bit 0 wait-for-interrupt, bit 1 interrupt, bit 2 handler end
   task automatic pulse(input logic [2:0] m);
      evs <= m;
      repeat (3) @(posedge ref_clk);
      evs <= 3'h0;
      repeat (6) @(posedge ref_clk);
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      tally_and_finish();
   end
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      evs = 3'h0;
      alive = 1'b1;
      nrst = 1'b0;
      codes = '{32'h20, 32'h3f, 32'h01, 32'h00};
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      chk(mode_out, mclk_pkg::MODE_RUN);
      chk({main_pll_on, usb_pll_on, ctl_clk_on, analog_clk_on}, 4'hf);
      chk(usb_bypass, 1'b1);
      apb(1'b0, `ADDR_OWNER, 32'h0);
      chk(rd, 32'h1);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `ADDR_USB_MULT, codes[i]);
         chk(usb_mult, codes[i][5:0]);
         chk(usb_bypass, codes[i] == 32'h0);
      end
      apb(1'b1, `ADDR_PLL_CTL, 32'h1);
      chk(sys_src_pll, 1'b1);
      apb(1'b1, `ADDR_PLL_CTL, 32'h0);
      chk(sys_src_pll, 1'b0);
      apb(1'b1, 12'h03c, 32'h5);
      chk(err, 1'b1);
      apb(1'b1, `ADDR_DEV_CFG, 32'h00ff);
      apb(1'b1, `ADDR_RUN_GATE, 32'h0f0f);
      chk(periph_gate, 16'h000f);
      apb(1'b1, `ADDR_SLP_GATE, 32'h0103);
      apb(1'b1, `ADDR_RCC, 32'h1);
      pulse(3'h1);
      chk(mode_out, mclk_pkg::MODE_SLEEP);
      chk({cpu_clk_on, main_pll_on, ctl_clk_on}, 3'h3);
      chk(periph_gate, 16'h0003);
      pulse(3'h2);
      chk(mode_out, mclk_pkg::MODE_RUN);
      chk(periph_gate, 16'h000f);
      // Control core taken as already in standby before deep sleep
      apb(1'b1, `ADDR_DS_CFG, `DS_SRC_FAST);
      apb(1'b1, `ADDR_DS_GATE, 32'h01f0);
      apb(1'b1, `ADDR_SYS_CTRL, 32'h6);
      pulse(3'h1);
      chk(mode_out, mclk_pkg::MODE_DEEP);
      chk(ds_src, `DS_SRC_FAST);
      chk({main_pll_on, usb_pll_on, ctl_clk_on, analog_clk_on}, 4'h0);
      chk(periph_gate, 16'h00f0);
      pulse(3'h2);
      chk(mode_out, mclk_pkg::MODE_RUN);
      pulse(3'h4);
      chk(mode_out, mclk_pkg::MODE_DEEP);
      apb(1'b1, `ADDR_SYS_CTRL, 32'h4);
      pulse(3'h2);
      pulse(3'h4);
      chk(mode_out, mclk_pkg::MODE_RUN);
      apb(1'b1, `ADDR_RCC, 32'h0);
      apb(1'b1, `ADDR_SYS_CTRL, 32'h0);
      pulse(3'h1);
      chk(periph_gate, 16'h000f);
      pulse(3'h2);
      apb(1'b1, `ADDR_OWNER, 32'h1);
      apb(1'b0, `ADDR_OWNER, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, `ADDR_OWNER, 32'h5);
      apb(1'b0, `ADDR_OWNER, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, `ADDR_PLL_CTL, 32'h1);
      chk(sys_src_pll, 1'b0);
      apb(1'b1, `ADDR_OWNER, 32'ha);
      apb(1'b0, `ADDR_OWNER, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, `ADDR_PLL_CTL, 32'h1);
      chk(sys_src_pll, 1'b1);
      chk(clock_failure_signal, 1'b0);
      alive <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk(clock_failure_signal, 1'b1);
      chk(sys_src_backup, 1'b1);
      chk(analog_undivided, 1'b1);
      alive <= 1'b1;
      repeat (20) @(posedge ref_clk);
      chk(clock_failure_signal, 1'b1);
      tally_and_finish();
   end
endmodule
